/* File: i2cew_pkg.sv */
// Shared constants for the two-wire EEPROM write slave and its bus master
package i2cew_pkg;
	// Slave address layout
	localparam int CLASS_MSB = 7;
	localparam int CLASS_LSB = 4;
	localparam int SEL_MSB = 3;
	localparam int SEL_LSB = 1;
	localparam int DIR_BIT = 0;
	// Memory class code; the value is arbitrary and both ends share it
	localparam logic [3:0] I2CEW_CLASS = 4'h6;
	localparam logic DIR_READ = 1'b1;
	localparam logic DIR_WRITE = 1'b0;
	// Array geometry
	localparam int ADDR_W = 14;
	localparam int HI_USED = 6;
	localparam int PAGE_W = 6;
	localparam int PAGE_BYTES = 64;
	// Timing
	localparam int CLK_NS = 20;
	localparam int T_PROG_MS = 6;
	localparam int PROG_CYCLES = T_PROG_MS * 1000000 / CLK_NS;
	localparam int T_FILT_NS = 50;
	localparam int FILT_CYCLES = (T_FILT_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_SCL_NS = 10000;
	localparam int QTR_CYCLES = T_SCL_NS / 4 / CLK_NS;
	// Host register map (byte addresses)
	localparam logic [11:0] REG_CMD = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	// Command and status fields
	localparam int CMD_START = 8;
	localparam int CMD_STOP = 9;
	localparam int CMD_SEND = 10;
	localparam int STAT_BUSY = 0;
	localparam int STAT_NACK = 1;
	localparam logic [31:0] CMD_RST = 32'h0000_0000;
endpackage : i2cew_pkg

/* File: i2cew_if.sv */
// Two-wire link between the bus master and the EEPROM slave
`timescale 1ns/1ps
interface i2cew_if;
	logic scl;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_s_o;
	logic sda_s_oe;
	logic sda;
	// Open-drain wired AND with pull-up: only a driven low pulls the line
	assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
	modport dev (input scl, input sda, output sda_s_o, output sda_s_oe);
	modport host (output scl, input sda, output sda_m_o, output sda_m_oe);
endinterface : i2cew_if

/* File: i2cew_filt.sv */
// Two-flop synchroniser followed by a stability glitch filter
`timescale 1ns/1ps
module i2cew_filt #(
	parameter int FILT = 3
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Line in and filtered level out
	input wire logic async_in,
	output logic level_out
);
	logic meta_ff;
	logic sync_ff;
	logic [3:0] cnt_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff <= 1'b1;
			sync_ff <= 1'b1;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	// A level must hold FILT cycles before it is passed on, so short spikes vanish
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 4'h0;
			level_out <= 1'b1;
		end else if (sync_ff == level_out) begin
			cnt_ff <= 4'h0;
		end else if (cnt_ff == 4'(FILT - 1)) begin
			cnt_ff <= 4'h0;
			level_out <= sync_ff;
		end else begin
			cnt_ff <= cnt_ff + 4'h1;
		end
	end
endmodule : i2cew_filt

/* File: i2cew_eeprom.sv */
// EEPROM end: two-wire write slave with page buffer and self-timed program cycle
`timescale 1ns/1ps
// Behaviour
// - Address byte: class, select, direction LSB
// - Respond only when class field matches constant
// - Select field must equal chip select pins
// - Direction one is read, zero is write
// - Receiver pulls SDA low on ninth clock
// - High address byte first, then low byte
// - Top two high-address bits ignored, 16384 locations
// - Slave only pulls SDA low or releases
// - SDA moves only while SCL low
// - Ignore bus until a start is seen
// - Stop ends transfer; standby unless programming
// - Master drives clock; slave never does
// - Ack both address bytes and data; stop programs
// - Ignore everything during program cycle
// - Pages of 64 aligned bytes, programmed together
// - Page write may start mid-page
// - Address advances after each acknowledged byte
// - Offset wraps inside page, never next page
// - Over 64 bytes overwrite earlier ones
// - Poll: no ack busy, ack when done
// - Write protect: nack first data, no program
// - Write protect low allows whole-array writes
// - Program time at most 6 ms, SDA released
module i2cew_eeprom import i2cew_pkg::*; #(
	parameter int unsigned PROG_LEN = PROG_CYCLES
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Two-wire link
	i2cew_if.dev link,
	// Straps
	input wire logic [2:0] chip_select_pins,
	input wire logic write_protect,
	// Memory observation
	input wire logic [ADDR_W-1:0] mem_rd_addr,
	output logic [7:0] mem_rd_data,
	output logic prog_busy
);
	typedef enum logic [2:0] {
		D_IDLE = 3'b000,
		D_DEV = 3'b001,
		D_AHI = 3'b011,
		D_ALO = 3'b010,
		D_DATA = 3'b110,
		D_PROG = 3'b111,
		D_SKIP = 3'b101
	} i2cew_dstate_t;

	i2cew_dstate_t state_ff;
	i2cew_dstate_t nxt_state;
	logic scl_f;
	logic sda_f;
	logic scl_d_ff;
	logic sda_d_ff;
	logic [2:0] cs_meta_ff;
	logic [2:0] cs_ff;
	logic wp_meta_ff;
	logic wp_ff;
	logic [3:0] bitcnt_ff;
	logic [7:0] shift_ff;
	logic ack_ff;
	logic nxt_ack;
	logic [ADDR_W-1:0] addr_ff;
	logic [PAGE_BYTES-1:0] valid_ff;
	logic [18:0] prog_cnt_ff;
	logic [PAGE_W:0] copy_idx_ff;
	logic [7:0] pagebuf [0:PAGE_BYTES-1];
	logic [7:0] mem [0:(1<<ADDR_W)-1];
	logic start_cond;
	logic stop_cond;
	logic scl_rise;
	logic scl_fall;
	logic active;
	logic byte_done;
	logic prog_done;

	i2cew_filt #(.FILT(FILT_CYCLES)) u_scl_filt (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(link.scl),
		.level_out(scl_f)
	);

	i2cew_filt #(.FILT(FILT_CYCLES)) u_sda_filt (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(link.sda),
		.level_out(sda_f)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			scl_d_ff <= scl_f;
			sda_d_ff <= sda_f;
		end
	end

	// Straps are static but still cross into pclk through two flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cs_meta_ff <= 3'b000;
			cs_ff <= 3'b000;
			wp_meta_ff <= 1'b0;
			wp_ff <= 1'b0;
		end else begin
			cs_meta_ff <= chip_select_pins;
			cs_ff <= cs_meta_ff;
			wp_meta_ff <= write_protect;
			wp_ff <= wp_meta_ff;
		end
	end

	// SDA moving while SCL stays high is only ever a start or a stop
	assign start_cond = scl_f && scl_d_ff && sda_d_ff && !sda_f;
	assign stop_cond = scl_f && scl_d_ff && !sda_d_ff && sda_f;
	assign scl_rise = scl_f && !scl_d_ff;
	assign scl_fall = !scl_f && scl_d_ff;
	assign active = (state_ff == D_DEV) || (state_ff == D_AHI) || (state_ff == D_ALO) || (state_ff == D_DATA);
	assign byte_done = active && scl_fall && (bitcnt_ff == 4'h8);
	assign prog_done = (state_ff == D_PROG) && (prog_cnt_ff == 19'(PROG_LEN - 1));

	// Acknowledge decision for the byte just received
	always_comb begin
		nxt_ack = 1'b0;
		nxt_state = D_SKIP;
		unique case (state_ff)
			D_DEV: begin
				if ((shift_ff[CLASS_MSB:CLASS_LSB] == I2CEW_CLASS)
						&& (shift_ff[SEL_MSB:SEL_LSB] == cs_ff)) begin
					nxt_ack = 1'b1;
					// Reads are outside this block: acknowledged, then the line is left alone
					nxt_state = (shift_ff[DIR_BIT] == DIR_READ) ? D_SKIP : D_AHI;
				end
			end
			D_AHI: begin
				nxt_ack = 1'b1;
				nxt_state = D_ALO;
			end
			D_ALO: begin
				nxt_ack = 1'b1;
				nxt_state = D_DATA;
			end
			D_DATA: begin
				nxt_ack = !wp_ff;
				nxt_state = wp_ff ? D_SKIP : D_DATA;
			end
			default: begin
				nxt_ack = 1'b0;
				nxt_state = D_SKIP;
			end
		endcase
	end

	// Phase sequencing; nothing on the bus reaches it while programming
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= D_IDLE;
		end else if (state_ff == D_PROG) begin
			if (prog_done) begin
				state_ff <= D_IDLE;
			end
		end else if (start_cond) begin
			state_ff <= D_DEV;
		end else if (stop_cond) begin
			state_ff <= (|valid_ff) ? D_PROG : D_IDLE;
		end else if (byte_done) begin
			state_ff <= nxt_state;
		end
	end

	// Bit counter: eight data bits sampled on rising SCL, then the ninth clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bitcnt_ff <= 4'h0;
			shift_ff <= 8'h00;
		end else if (start_cond && state_ff != D_PROG) begin
			bitcnt_ff <= 4'h0;
		end else if (active && scl_rise && bitcnt_ff < 4'h8) begin
			shift_ff <= {shift_ff[6:0], sda_f};
			bitcnt_ff <= bitcnt_ff + 4'h1;
		end else if (byte_done) begin
			bitcnt_ff <= 4'h9;
		end else if (scl_fall && bitcnt_ff == 4'h9) begin
			bitcnt_ff <= 4'h0;
		end
	end

	// Acknowledge: pulled low from the eighth falling edge to the ninth
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_ff <= 1'b0;
		end else if (state_ff == D_PROG || (start_cond && state_ff != D_PROG)) begin
			ack_ff <= 1'b0;
		end else if (byte_done) begin
			ack_ff <= nxt_ack;
		end else if (scl_fall) begin
			ack_ff <= 1'b0;
		end
	end

	assign link.sda_s_o = 1'b0;
	assign link.sda_s_oe = ack_ff;

	// Address counter: high byte keeps six bits, data bytes move only the offset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_ff <= '0;
		end else if (byte_done) begin
			unique case (state_ff)
				D_AHI: addr_ff[ADDR_W-1:8] <= shift_ff[HI_USED-1:0];
				D_ALO: addr_ff[7:0] <= shift_ff;
				D_DATA: begin
					if (!wp_ff) begin
						addr_ff[PAGE_W-1:0] <= addr_ff[PAGE_W-1:0] + 6'h01;
					end
				end
				default: addr_ff <= addr_ff;
			endcase
		end
	end

	// Page buffer: a later byte at the same offset replaces the earlier one
	always_ff @(posedge pclk) begin
		if (byte_done && state_ff == D_DATA && !wp_ff) begin
			pagebuf[addr_ff[PAGE_W-1:0]] <= shift_ff;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			valid_ff <= '0;
		end else if (prog_done || (start_cond && state_ff != D_PROG)) begin
			valid_ff <= '0;
		end else if (byte_done && state_ff == D_DATA && !wp_ff) begin
			valid_ff[addr_ff[PAGE_W-1:0]] <= 1'b1;
		end
	end

	// Program cycle: copy the page in the first cycles, then wait out the full time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prog_cnt_ff <= '0;
			copy_idx_ff <= '0;
		end else if (state_ff != D_PROG) begin
			prog_cnt_ff <= '0;
			copy_idx_ff <= '0;
		end else begin
			prog_cnt_ff <= prog_cnt_ff + 19'h0_0001;
			if (copy_idx_ff != 7'(PAGE_BYTES)) begin
				copy_idx_ff <= copy_idx_ff + 7'h01;
			end
		end
	end

	always_ff @(posedge pclk) begin
		if (state_ff == D_PROG && copy_idx_ff != 7'(PAGE_BYTES) && valid_ff[copy_idx_ff[PAGE_W-1:0]]) begin
			mem[{addr_ff[ADDR_W-1:PAGE_W], copy_idx_ff[PAGE_W-1:0]}] <= pagebuf[copy_idx_ff[PAGE_W-1:0]];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_rd_data <= 8'h00;
		end else begin
			mem_rd_data <= mem[mem_rd_addr];
		end
	end

	assign prog_busy = (state_ff == D_PROG);
endmodule : i2cew_eeprom

/* File: i2cew_master.sv */
// Host end: APB-controlled two-wire bus master issuing start, byte and stop steps
`timescale 1ns/1ps
module i2cew_master import i2cew_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Two-wire link
	i2cew_if.host link
);
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_START = 2'b01,
		H_BITS = 2'b11,
		H_STOP = 2'b10
	} i2cew_hstate_t;

	i2cew_hstate_t state_ff;
	logic [31:0] cmd_ff;
	logic nack_ff;
	logic [7:0] shift_ff;
	logic [3:0] bit_ff;
	logic [1:0] q_ff;
	logic [7:0] div_ff;
	logic tick;
	logic scl_ff;
	logic oe_ff;
	logic sda_meta_ff;
	logic sda_sync_ff;
	logic wr_cmd;
	logic rd_ok;

	// Zero wait state: every access completes in its first access cycle
	assign pready = 1'b1;
	assign rd_ok = (paddr == REG_CMD) || (paddr == REG_STATUS);
	assign pslverr = psel && penable && !rd_ok;
	assign wr_cmd = psel && penable && pwrite && (paddr == REG_CMD) && (state_ff == H_IDLE);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			if (paddr == REG_CMD) begin
				prdata <= cmd_ff;
			end else if (paddr == REG_STATUS) begin
				prdata <= {30'h0000_0000, nack_ff, state_ff != H_IDLE};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sda_meta_ff <= 1'b1;
			sda_sync_ff <= 1'b1;
		end else begin
			sda_meta_ff <= link.sda;
			sda_sync_ff <= sda_meta_ff;
		end
	end

	// Quarter-period divider, restarted by each command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_ff <= 8'h00;
		end else if (wr_cmd || tick) begin
			div_ff <= 8'h00;
		end else if (state_ff != H_IDLE) begin
			div_ff <= div_ff + 8'h01;
		end
	end

	assign tick = (state_ff != H_IDLE) && (div_ff == 8'(QTR_CYCLES - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_ff <= CMD_RST;
		end else if (wr_cmd) begin
			cmd_ff <= pwdata;
		end
	end

	// Bus sequencer; SCL is driven low in the step that sets the data level, then driven high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= H_IDLE;
			q_ff <= 2'b00;
			bit_ff <= 4'h0;
			shift_ff <= 8'h00;
			scl_ff <= 1'b1;
			oe_ff <= 1'b0;
			nack_ff <= 1'b0;
		end else if (wr_cmd) begin
			q_ff <= 2'b00;
			bit_ff <= 4'h0;
			shift_ff <= pwdata[7:0];
			nack_ff <= 1'b0;
			if (pwdata[CMD_START]) begin
				state_ff <= H_START;
			end else if (pwdata[CMD_SEND]) begin
				state_ff <= H_BITS;
			end else if (pwdata[CMD_STOP]) begin
				state_ff <= H_STOP;
			end
		end else if (tick) begin
			q_ff <= q_ff + 2'b01;
			unique case (state_ff)
				H_START: begin
					unique case (q_ff)
						2'b00: begin
							scl_ff <= 1'b0;
							oe_ff <= 1'b0;
						end
						2'b01: scl_ff <= 1'b1;
						2'b10: oe_ff <= 1'b1;
						2'b11: begin
							scl_ff <= 1'b0;
							state_ff <= cmd_ff[CMD_SEND] ? H_BITS : (cmd_ff[CMD_STOP] ? H_STOP : H_IDLE);
						end
					endcase
				end
				H_BITS: begin
					unique case (q_ff)
						2'b00: begin
							scl_ff <= 1'b0;
							oe_ff <= (bit_ff < 4'h8) ? !shift_ff[7] : 1'b0;
						end
						2'b01: scl_ff <= 1'b1;
						2'b10: begin
							if (bit_ff == 4'h8) begin
								nack_ff <= sda_sync_ff;
							end
						end
						2'b11: begin
							scl_ff <= 1'b0;
							shift_ff <= {shift_ff[6:0], 1'b0};
							bit_ff <= bit_ff + 4'h1;
							if (bit_ff == 4'h8) begin
								state_ff <= cmd_ff[CMD_STOP] ? H_STOP : H_IDLE;
							end
						end
					endcase
				end
				H_STOP: begin
					unique case (q_ff)
						2'b00: begin
							scl_ff <= 1'b0;
							oe_ff <= 1'b1;
						end
						2'b01: scl_ff <= 1'b1;
						2'b10: oe_ff <= 1'b0;
						2'b11: state_ff <= H_IDLE;
					endcase
				end
				default: state_ff <= H_IDLE;
			endcase
		end
	end

	assign link.scl = scl_ff;
	assign link.sda_m_o = 1'b0;
	assign link.sda_m_oe = oe_ff;
endmodule : i2cew_master

/* File: i2cew_monitor.sv */
// Concurrent checks on the two-wire link between the master and EEPROM ends
`timescale 1ns/1ps
module i2cew_monitor #(
	parameter int unsigned PROG_LEN = 200
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link and status
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_s_o,
	input wire logic sda_s_oe,
	input wire logic prog_busy
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic seen_start_ff;
	int busy_cnt_ff;
	int since_stop_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) seen_start_ff <= 1'b0;
		else if (scl && $fell(sda)) seen_start_ff <= 1'b1;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) busy_cnt_ff <= 0;
		else busy_cnt_ff <= prog_busy ? busy_cnt_ff + 1 : 0;
	end
	// Saturates so a long idle never wraps into a false match
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) since_stop_ff <= 1000;
		else if (scl && $rose(sda)) since_stop_ff <= 0;
		else if (since_stop_ff < 1000) since_stop_ff <= since_stop_ff + 1;
	end
	property p_pull_only; sda_s_oe |-> !sda_s_o; endproperty
	a_pull_only: assert property (p_pull_only) else $error("slave drives sda high");
	property p_move_low; $changed(sda_s_oe) |-> !scl; endproperty
	a_move_low: assert property (p_move_low) else $error("slave moves sda while scl high");
	property p_ack_hold; $rose(scl) && sda_s_oe |-> sda_s_oe [*8]; endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("ack dropped during clock high");
	property p_ack_release; $fell(scl) && sda_s_oe |-> ##[1:20] !sda_s_oe; endproperty
	a_ack_release: assert property (p_ack_release) else $error("ack not released after ninth clock");
	property p_after_start; sda_s_oe |-> seen_start_ff; endproperty
	a_after_start: assert property (p_after_start) else $error("slave active before any start");
	property p_busy_quiet; prog_busy |-> !sda_s_oe; endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("slave pulls sda while programming");
	property p_busy_len; busy_cnt_ff <= PROG_LEN; endproperty
	a_busy_len: assert property (p_busy_len) else $error("program cycle too long");
	property p_prog_cause; $rose(prog_busy) |-> since_stop_ff <= 20; endproperty
	a_prog_cause: assert property (p_prog_cause) else $error("program cycle without stop");
	c_ack: cover property ($rose(sda_s_oe));
	c_prog: cover property ($rose(prog_busy));
	c_stop: cover property (scl && $rose(sda));
endmodule : i2cew_monitor

/* File: i2cew_bench.sv */
// Self-checking bench joining the APB two-wire master to the EEPROM end
`timescale 1ns/1ps
module i2cew_bench import i2cew_pkg::*;;
	// Long enough that a poll issued right after stop lands inside it
	localparam int unsigned PLEN = 6000;
	localparam logic [2:0] PINS = 3'b011;
	localparam logic [7:0] DEV_W = {I2CEW_CLASS, PINS, DIR_WRITE};
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic write_protect = 1'b0;
	logic prog_busy;
	logic [13:0] mem_rd_addr = 14'h0000;
	logic [7:0] mem_rd_data;
	int miscompares = 0;
	int cmp_count = 0;
	always #10 pclk = ~pclk;
	i2cew_if link_if();
	i2cew_master i2cew_master_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link_if.host));
	i2cew_eeprom #(.PROG_LEN(PLEN)) i2cew_eeprom_inst (.pclk(pclk), .presetn(presetn),
		.link(link_if.dev), .chip_select_pins(PINS), .write_protect(write_protect),
		.mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data), .prog_busy(prog_busy));
	i2cew_monitor #(.PROG_LEN(PLEN)) i2cew_monitor_inst (.pclk(pclk), .presetn(presetn),
		.scl(link_if.scl), .sda(link_if.sda), .sda_s_o(link_if.sda_s_o),
		.sda_s_oe(link_if.sda_s_oe), .prog_busy(prog_busy));
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t %s: saw %h expected %h", $time, what, seen, exp);
		end
	endtask : chk
	task automatic fail_out(input string what);
		miscompares++;
		$display("ERROR %0t timeout in %s", $time, what);
		stop_test();
	endtask : fail_out
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		int n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (n >= 100) fail_out("apb");
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// One bus step; the step's acknowledge outcome is judged here
	task automatic send(input logic st, input logic sp, input logic [7:0] b, input logic exp_nack);
		logic [31:0] q;
		int n = 0;
		apb(1'b1, REG_CMD, {21'h00_0000, 1'b1, sp, st, b}, q);
		repeat (2) @(posedge pclk);
		do begin
			apb(1'b0, REG_STATUS, 32'h0000_0000, q);
			n++;
		end while (q[STAT_BUSY] !== 1'b0 && n < 5000);
		if (n >= 5000) fail_out("step");
		chk({7'h00, q[STAT_NACK]}, {7'h00, exp_nack}, "acknowledge");
	endtask : send
	task automatic wait_idle();
		int n = 0;
		repeat (20) @(posedge pclk);
		while (prog_busy !== 1'b0 && n < 20000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 20000) fail_out("program");
	endtask : wait_idle
	task automatic peek(input logic [13:0] a, input logic [7:0] exp);
		mem_rd_addr <= a;
		repeat (3) @(posedge pclk);
		chk(mem_rd_data, exp, "memory");
	endtask : peek
	task automatic s_byte_write();
		send(1'b1, 1'b0, DEV_W, 1'b0);
		send(1'b0, 1'b0, 8'hC1, 1'b0);
		send(1'b0, 1'b0, 8'h23, 1'b0);
		send(1'b0, 1'b1, 8'h5A, 1'b0);
		repeat (20) @(posedge pclk);
		chk({7'h00, prog_busy}, 8'h01, "busy after stop");
		send(1'b1, 1'b1, DEV_W, 1'b1);
		wait_idle();
		send(1'b1, 1'b1, DEV_W, 1'b0);
		peek(14'h0123, 8'h5A);
	endtask : s_byte_write
	task automatic s_addr_refuse();
		send(1'b1, 1'b1, {~I2CEW_CLASS, PINS, DIR_WRITE}, 1'b1);
		send(1'b1, 1'b1, {I2CEW_CLASS, 3'b110, DIR_WRITE}, 1'b1);
		send(1'b1, 1'b1, {I2CEW_CLASS, PINS, DIR_READ}, 1'b0);
		repeat (20) @(posedge pclk);
		chk({7'h00, prog_busy}, 8'h00, "standby after stop");
	endtask : s_addr_refuse
	task automatic s_page_wrap();
		send(1'b1, 1'b0, DEV_W, 1'b0);
		send(1'b0, 1'b0, 8'h00, 1'b0);
		send(1'b0, 1'b0, 8'h7E, 1'b0);
		send(1'b0, 1'b0, 8'hA1, 1'b0);
		send(1'b0, 1'b0, 8'hA2, 1'b0);
		send(1'b0, 1'b1, 8'hA3, 1'b0);
		wait_idle();
		peek(14'h007E, 8'hA1);
		peek(14'h007F, 8'hA2);
		peek(14'h0040, 8'hA3);
	endtask : s_page_wrap
	task automatic s_protect();
		write_protect <= 1'b1;
		send(1'b1, 1'b0, DEV_W, 1'b0);
		send(1'b0, 1'b0, 8'h00, 1'b0);
		send(1'b0, 1'b0, 8'h40, 1'b0);
		send(1'b0, 1'b1, 8'h55, 1'b1);
		repeat (20) @(posedge pclk);
		chk({7'h00, prog_busy}, 8'h00, "busy when protected");
		peek(14'h0040, 8'hA3);
		write_protect <= 1'b0;
	endtask : s_protect
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (10) @(posedge pclk);
		s_byte_write();
		s_addr_refuse();
		s_page_wrap();
		s_protect();
		stop_test();
	end
endmodule : i2cew_bench
